/* File: pkg/cie_pkg.sv */
package cie_pkg;

  localparam int DATA_W = 16;

  // Instruction word, bit 15 is the most significant bit.
  localparam logic [7:0] IO_GROUP      = 8'h30;
  localparam int         GROUP_LSB     = 8;
  localparam int         SUB_LSB       = 4;
  localparam int         K_LSB         = 0;
  localparam int         K_W           = 4;
  localparam logic [3:0] SUB_CONTROL   = 4'hB;
  localparam logic [3:0] SUB_READ      = 4'h8;
  localparam logic [3:0] SUB_WRITE     = 4'h9;
  localparam logic [3:0] SUB_START     = 4'h7;
  localparam logic [3:0] SUB_TEST      = 4'hA;
  localparam logic [3:0] SUB_MODULE    = 4'hC;

  // Module command word fields and controller status bits.
  localparam int MOD_NUM_LSB       = 0;
  localparam int MOD_NUM_W         = 3;
  localparam int MOD_CMD_LSB       = 4;
  localparam int MOD_CMD_W         = 2;
  localparam int STAT_READY_BIT    = 14;
  localparam int STAT_START_OK_BIT = 15;

  // Table entry layout for channel program start addresses.
  localparam int DTAB_ENTRY_WORDS = 4;

  // APB map, byte addresses.
  localparam logic [11:0] REG_INSTR  = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_STACK  = 12'h008;
  localparam logic [11:0] REG_POP    = 12'h00C;
  localparam logic [11:0] REG_TABLE  = 12'h010;
  localparam logic [11:0] REG_MODE   = 12'h014;

  // Status register fields.
  localparam int ST_BUSY      = 0;
  localparam int ST_CC_LSB    = 1;
  localparam int ST_MODE_TRAP = 3;
  localparam int ST_UNDER     = 4;
  localparam int ST_OVER      = 5;
  localparam int ST_BADOP     = 6;
  localparam int ST_DEPTH_LSB = 8;

  // No-response timeout, a least wait, so rounded up.
  localparam int NORESP_NS     = 1000;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int NORESP_CYC    = (NORESP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    OP_NONE, OP_CONTROL, OP_READ, OP_WRITE, OP_START, OP_TEST, OP_MODULE
  } cie_op_e;

  typedef enum logic [2:0] {
    KIND_STATUS, KIND_CONTROL, KIND_READ, KIND_WRITE, KIND_START
  } cie_kind_e;

  typedef enum logic [1:0] {
    CC_GREATER = 2'h0,
    CC_LESS    = 2'h1,
    CC_EQUAL   = 2'h2
  } cie_cc_e;

  typedef struct packed {
    logic              valid;
    cie_kind_e         kind;
    logic [DATA_W-1:0] devnum;
    logic [DATA_W-1:0] data;
  } cie_io_req_s;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] data;
  } cie_io_rsp_s;

  typedef struct packed {
    logic                 valid;
    logic [MOD_NUM_W-1:0] modnum;
    logic [MOD_CMD_W-1:0] cmd;
    logic [DATA_W-1:0]    data;
  } cie_mod_req_s;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cie_dtab_wr_s;

endpackage

/* File: rtl/cie_stack_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module cie_stack_mem #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // Write port
  input  wire logic              we_in,
  input  wire logic [ADDR_W-1:0] waddr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  // Read port, one cycle latency
  input  wire logic [ADDR_W-1:0] raddr_in,
  output logic      [DATA_W-1:0] rdata_out
);

  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/cie_io_exec.sv */
// Summary of operation
// - A control operation sends the top word with a control strobe to the device named at depth K, and on acknowledge pops it and sets equal.
// - A controller that does not answer leaves the stack untouched, sets less-than and ends the instruction.
// - A module command takes the module number from the low three bits and the command from bits five and four of the word at depth K, sends them with the top word, then pops it.
// - A module command stalls until the module is ready, and the module alone gives the command its meaning.
// - A module command needs privileged mode, leaves the condition code alone and may raise underflow or mode traps.
// - A read checks the ready status bit and, when set, pushes the controller data word and sets equal.
// - When the tested readiness bit is clear for read, write or start, the whole status word is pushed and greater-than is set.
// - A write with ready status sends the top word to the device, pops it and sets equal.
// - A start uses the top word as the channel program address and first tests the start-ok status bit.
// - With start-ok set, the address is written into the device's table entry, a start is issued, the top word is popped and equal is set.
// - A test fetches the status word, pushes it and sets equal without any readiness check.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cie_io_exec
  import cie_pkg::*;
#(
  parameter int DEPTH_W       = 4,
  parameter int NORESP_CYCLES = cie_pkg::NORESP_CYC
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  // APB slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [11:0]          paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // Device controllers
  output cie_pkg::cie_io_req_s      io_req_out,
  input  wire cie_pkg::cie_io_rsp_s io_rsp_in,
  // System modules over the central data bus
  output cie_pkg::cie_mod_req_s     mod_req_out,
  input  wire logic                 mod_ready_in,
  // Device table writes
  output cie_pkg::cie_dtab_wr_s     dtab_wr_out
);
  import cie_pkg::*;

  localparam int SP_W = DEPTH_W + 1;
  localparam int TW   = $clog2(NORESP_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD_K = 3'h1,
    ST_RD_T = 3'h3,
    ST_STAT = 3'h2,
    ST_DTAB = 3'h6,
    ST_OP   = 3'h7,
    ST_PUSH = 3'h5
  } cie_st_e;

  function automatic cie_op_e op_decode(input logic [DATA_W-1:0] w);
    cie_op_e op;
    op = OP_NONE;
    if (w[GROUP_LSB+:8] == IO_GROUP) begin
      case (w[SUB_LSB+:4])
        SUB_CONTROL: op = OP_CONTROL;
        SUB_READ:    op = OP_READ;
        SUB_WRITE:   op = OP_WRITE;
        SUB_START:   op = OP_START;
        SUB_TEST:    op = OP_TEST;
        SUB_MODULE:  op = OP_MODULE;
        default:     op = OP_NONE;
      endcase
    end
    return op;
  endfunction

  cie_st_e           state_q;
  cie_op_e           op_q;
  cie_cc_e           cc_q;
  logic [DATA_W-1:0] arg_q;
  logic [DATA_W-1:0] top_q;
  logic [DATA_W-1:0] stat_q;
  logic [DATA_W-1:0] push_q;
  logic [DATA_W-1:0] table_q;
  logic [DATA_W-1:0] dtab_addr_q;
  logic [SP_W-1:0]   sp_q;
  logic [TW-1:0]     timer_q;
  logic              mode_q;
  logic              rd_wait_q;
  logic              f_mode_q;
  logic              f_under_q;
  logic              f_over_q;
  logic              f_badop_q;

  logic              busy;
  logic              apb_acc;
  logic              mapped;
  logic              stack_rd;
  logic              refused;
  logic              apb_wr;
  logic              start_w;
  cie_op_e           new_op;
  logic [K_W-1:0]    new_k;
  logic              set_mode;
  logic              set_under;
  logic              set_badop;
  logic              go_w;
  logic              full;
  logic              apb_push;
  logic              apb_pop;
  logic              exec_pop;
  logic              exec_push;
  logic              timeout_w;
  logic              ready_w;
  logic              mem_we;
  logic [DEPTH_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DEPTH_W-1:0] mem_raddr;
  logic [DATA_W-1:0] mem_rdata;

  // APB decode. Stack reads wait one cycle for the memory and wait out a busy instruction.
  assign busy     = (state_q != ST_IDLE);
  assign apb_acc  = psel_in && penable_in;
  assign mapped   = (paddr_in == REG_INSTR) || (paddr_in == REG_STATUS) || (paddr_in == REG_STACK) ||
                    (paddr_in == REG_POP) || (paddr_in == REG_TABLE) || (paddr_in == REG_MODE);
  assign stack_rd = !pwrite_in && (paddr_in == REG_STACK);
  assign full     = (sp_q == SP_W'(2**DEPTH_W));
  assign refused  = pwrite_in && (busy || ((paddr_in == REG_STACK) && full) ||
                    ((paddr_in == REG_POP) && (sp_q == '0))) &&
                    ((paddr_in == REG_INSTR) || (paddr_in == REG_STACK) || (paddr_in == REG_POP));
  assign pready_out  = stack_rd ? rd_wait_q : 1'b1;
  assign pslverr_out = apb_acc && pready_out && (!mapped || refused);
  assign apb_wr      = apb_acc && pwrite_in && mapped && !refused;
  assign apb_push    = apb_wr && (paddr_in == REG_STACK);
  assign apb_pop     = apb_wr && (paddr_in == REG_POP);
  assign start_w     = apb_wr && (paddr_in == REG_INSTR);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_wait_q <= 1'b0;
    end else begin
      rd_wait_q <= apb_acc && psel_in && stack_rd && !rd_wait_q && !busy;
    end
  end

  always_comb begin
    prdata_out = '0;
    case (paddr_in)
      REG_STATUS: begin
        prdata_out[ST_BUSY]                = busy;
        prdata_out[ST_CC_LSB+:2]           = cc_q;
        prdata_out[ST_MODE_TRAP]           = f_mode_q;
        prdata_out[ST_UNDER]               = f_under_q;
        prdata_out[ST_OVER]                = f_over_q;
        prdata_out[ST_BADOP]               = f_badop_q;
        prdata_out[ST_DEPTH_LSB+:SP_W]     = sp_q;
      end
      REG_STACK: prdata_out[DATA_W-1:0] = (sp_q == '0) ? '0 : mem_rdata;
      REG_TABLE: prdata_out[DATA_W-1:0] = table_q;
      REG_MODE:  prdata_out[0]          = mode_q;
      REG_INSTR: prdata_out[SUB_LSB+:4] = '0;
      default:   prdata_out = '0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      table_q <= '0;
      mode_q  <= 1'b0;
    end else begin
      if (apb_wr && (paddr_in == REG_TABLE)) begin
        table_q <= pwdata_in[DATA_W-1:0];
      end
      if (apb_wr && (paddr_in == REG_MODE)) begin
        mode_q <= pwdata_in[0];
      end
    end
  end

  assign new_op    = op_decode(pwdata_in[DATA_W-1:0]);
  assign new_k     = pwdata_in[K_LSB+:K_W];
  assign set_badop = start_w && (new_op == OP_NONE);
  assign set_mode  = start_w && (new_op == OP_MODULE) && !mode_q;
  assign set_under = start_w && (new_op != OP_NONE) && !set_mode && (sp_q <= SP_W'(new_k));
  assign go_w      = start_w && !set_badop && !set_mode && !set_under;

  // Trap flags are sticky; a write of ones clears them, but a new event in that cycle wins.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      f_mode_q  <= 1'b0;
      f_under_q <= 1'b0;
      f_over_q  <= 1'b0;
      f_badop_q <= 1'b0;
    end else begin
      f_mode_q  <= set_mode || (f_mode_q &&
                   !(apb_wr && (paddr_in == REG_STATUS) && pwdata_in[ST_MODE_TRAP]));
      f_under_q <= set_under || (f_under_q &&
                   !(apb_wr && (paddr_in == REG_STATUS) && pwdata_in[ST_UNDER]));
      f_over_q  <= (exec_push && full) || (f_over_q &&
                   !(apb_wr && (paddr_in == REG_STATUS) && pwdata_in[ST_OVER]));
      f_badop_q <= set_badop || (f_badop_q &&
                   !(apb_wr && (paddr_in == REG_STATUS) && pwdata_in[ST_BADOP]));
    end
  end

  assign timeout_w = io_req_out.valid && !io_rsp_in.ack && (timer_q == TW'(NORESP_CYCLES - 1));

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_q <= '0;
    end else if (!io_req_out.valid || io_rsp_in.ack || timeout_w) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_q + TW'(1);
    end
  end

  assign ready_w = (op_q == OP_START) ? io_rsp_in.status[STAT_START_OK_BIT]
                                      : io_rsp_in.status[STAT_READY_BIT];

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q    <= ST_IDLE;
      op_q       <= OP_NONE;
      cc_q       <= CC_GREATER;
      arg_q       <= '0;
      top_q       <= '0;
      stat_q      <= '0;
      push_q      <= '0;
      dtab_addr_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go_w) begin
            op_q    <= new_op;
            state_q <= ST_RD_K;
          end
        end
        ST_RD_K: begin
          arg_q   <= mem_rdata;
          state_q <= ST_RD_T;
        end
        ST_RD_T: begin
          top_q       <= mem_rdata;
          dtab_addr_q <= DATA_W'(table_q + DATA_W'(arg_q * DTAB_ENTRY_WORDS));
          state_q    <= ((op_q == OP_CONTROL) || (op_q == OP_MODULE)) ? ST_OP : ST_STAT;
        end
        ST_STAT: begin
          if (io_rsp_in.ack) begin
            stat_q <= io_rsp_in.status;
            push_q <= io_rsp_in.status;
            if (op_q == OP_TEST) begin
              cc_q    <= CC_EQUAL;
              state_q <= ST_PUSH;
            end else if (ready_w) begin
              state_q <= (op_q == OP_START) ? ST_DTAB : ST_OP;
            end else begin
              cc_q    <= CC_GREATER;
              state_q <= ST_PUSH;
            end
          end else if (timeout_w) begin
            cc_q    <= CC_LESS;
            state_q <= ST_IDLE;
          end
        end
        ST_DTAB: begin
          state_q <= ST_OP;
        end
        ST_OP: begin
          if (op_q == OP_MODULE) begin
            if (mod_ready_in) begin
              state_q <= ST_IDLE;
            end
          end else if (io_rsp_in.ack) begin
            cc_q <= CC_EQUAL;
            if (op_q == OP_READ) begin
              push_q  <= io_rsp_in.data;
              state_q <= ST_PUSH;
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (timeout_w) begin
            cc_q    <= CC_LESS;
            state_q <= ST_IDLE;
          end
        end
        ST_PUSH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign exec_pop  = (state_q == ST_OP) && (((op_q == OP_MODULE) && mod_ready_in) ||
                     (io_rsp_in.ack && (op_q != OP_READ) && (op_q != OP_MODULE)));
  assign exec_push = (state_q == ST_PUSH);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sp_q <= '0;
    end else if (exec_pop || apb_pop) begin
      sp_q <= sp_q - SP_W'(1);
    end else if ((exec_push || apb_push) && !full) begin
      sp_q <= sp_q + SP_W'(1);
    end
  end

  // An instruction push onto a full stack drops the word and raises the overflow flag; an APB push onto a full stack is refused.
  assign mem_we    = (exec_push || apb_push) && !full;
  assign mem_waddr = DEPTH_W'(sp_q);
  assign mem_wdata = exec_push ? push_q : pwdata_in[DATA_W-1:0];
  assign mem_raddr = go_w ? DEPTH_W'(sp_q - SP_W'(new_k) - SP_W'(1)) : DEPTH_W'(sp_q - SP_W'(1));

  cie_stack_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (DEPTH_W)
  ) u_stack (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .we_in     (mem_we),
    .waddr_in  (mem_waddr),
    .wdata_in  (mem_wdata),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_rdata)
  );

  always_comb begin
    io_req_out        = '0;
    io_req_out.devnum = arg_q;
    io_req_out.data   = top_q;
    io_req_out.valid  = (state_q == ST_STAT) || ((state_q == ST_OP) && (op_q != OP_MODULE));
    io_req_out.kind   = KIND_STATUS;
    if (state_q == ST_OP) begin
      case (op_q)
        OP_CONTROL: io_req_out.kind = KIND_CONTROL;
        OP_READ:    io_req_out.kind = KIND_READ;
        OP_WRITE:   io_req_out.kind = KIND_WRITE;
        OP_START:   io_req_out.kind = KIND_START;
        default:    io_req_out.kind = KIND_STATUS;
      endcase
    end
  end

  assign mod_req_out.valid  = (state_q == ST_OP) && (op_q == OP_MODULE);
  assign mod_req_out.modnum = arg_q[MOD_NUM_LSB+:MOD_NUM_W];
  assign mod_req_out.cmd    = arg_q[MOD_CMD_LSB+:MOD_CMD_W];
  assign mod_req_out.data   = top_q;

  assign dtab_wr_out.valid = (state_q == ST_DTAB);
  assign dtab_wr_out.addr  = dtab_addr_q;
  assign dtab_wr_out.data  = top_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_ctl_ack;
    (state_q == ST_OP && op_q == OP_CONTROL && io_rsp_in.ack)
      |=> (cc_q == CC_EQUAL && sp_q == $past(sp_q) - SP_W'(1) && state_q == ST_IDLE);
  endproperty
  a_ctl_ack: assert property (p_ctl_ack)
    else $error("control ack did not pop and set equal");

  property p_noresp;
    timeout_w |=> (cc_q == CC_LESS && sp_q == $past(sp_q) && state_q == ST_IDLE);
  endproperty
  a_noresp: assert property (p_noresp)
    else $error("no response did not end with less and kept stack");

  property p_cmd_stall;
    (mod_req_out.valid && !mod_ready_in)
      |=> (mod_req_out.valid && $stable(mod_req_out.data) && $stable(mod_req_out.cmd) && $stable(mod_req_out.modnum));
  endproperty
  a_cmd_stall: assert property (p_cmd_stall)
    else $error("module request dropped before ready");

  property p_cmd_done;
    (mod_req_out.valid && mod_ready_in) |=> (sp_q == $past(sp_q) - SP_W'(1) && $stable(cc_q) && !busy);
  endproperty
  a_cmd_done: assert property (p_cmd_done)
    else $error("module command did not pop or changed condition");

  property p_cmd_mode;
    (start_w && new_op == OP_MODULE && !mode_q) |=> (f_mode_q && !busy);
  endproperty
  a_cmd_mode: assert property (p_cmd_mode)
    else $error("module command ran outside privileged mode");

  property p_read_ok;
    (state_q == ST_OP && op_q == OP_READ && io_rsp_in.ack)
      |=> (state_q == ST_PUSH && cc_q == CC_EQUAL && push_q == $past(io_rsp_in.data)) ##1 (sp_q == $past(sp_q, 2) + SP_W'(1) || f_over_q);
  endproperty
  a_read_ok: assert property (p_read_ok)
    else $error("read did not push data with equal");

  property p_not_ready;
    (state_q == ST_STAT && io_rsp_in.ack && (op_q == OP_READ || op_q == OP_WRITE) && !io_rsp_in.status[STAT_READY_BIT])
      |=> (state_q == ST_PUSH && cc_q == CC_GREATER && push_q == $past(io_rsp_in.status));
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("not ready did not push status with greater");

  property p_write_data;
    (io_req_out.valid && io_req_out.kind == KIND_WRITE) |-> (io_req_out.data == top_q && stat_q[STAT_READY_BIT]);
  endproperty
  a_write_data: assert property (p_write_data)
    else $error("write sent without ready or wrong word");

  property p_start_bit;
    (state_q == ST_STAT && io_rsp_in.ack && op_q == OP_START)
      |=> ((state_q == ST_DTAB) == $past(io_rsp_in.status[STAT_START_OK_BIT]));
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start did not follow start-ok bit");

  property p_dtab_then_start;
    (state_q == ST_DTAB) |-> (dtab_wr_out.data == top_q) ##1 (io_req_out.valid && io_req_out.kind == KIND_START);
  endproperty
  a_dtab_then_start: assert property (p_dtab_then_start)
    else $error("table write not followed by start command");

  property p_test;
    (state_q == ST_STAT && op_q == OP_TEST && io_rsp_in.ack) |=> (state_q == ST_PUSH && cc_q == CC_EQUAL);
  endproperty
  a_test: assert property (p_test)
    else $error("test did not push status with equal");

  c_ctl_ok:   cover property (state_q == ST_OP && op_q == OP_CONTROL && io_rsp_in.ack);
  c_rd_busy:  cover property (state_q == ST_STAT && op_q == OP_READ && io_rsp_in.ack && !ready_w);
  c_cmd_wait: cover property (mod_req_out.valid && !mod_ready_in ##1 mod_ready_in);
  c_start_ok: cover property (state_q == ST_DTAB);

endmodule
`default_nettype wire

/* File: testbench/cie_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cie_dev_model
  import cie_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  // Requests from the executor
  input  wire cie_pkg::cie_io_req_s  io_req_in,
  input  wire cie_pkg::cie_mod_req_s mod_req_in,
  // Behaviour set by the bench
  input  wire logic                  mute_in,
  input  wire logic [15:0]           stat_in,
  input  wire logic [15:0]           data_in,
  // Answers
  output cie_pkg::cie_io_rsp_s       io_rsp_out,
  output logic                       mod_ready_out
);
  logic [1:0] cnt_q;
  logic [1:0] mcnt_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q      <= 2'h0;
      io_rsp_out <= '0;
    end else begin
      // Outside an answer the data lines wander, so nothing stale can be mistaken for a reply.
      io_rsp_out.ack    <= 1'b0;
      io_rsp_out.status <= ~io_rsp_out.status;
      io_rsp_out.data   <= ~io_rsp_out.data;
      cnt_q             <= (io_req_in.valid && !io_rsp_out.ack) ? cnt_q + 2'h1 : 2'h0;
      if (io_req_in.valid && !io_rsp_out.ack && cnt_q == 2'h2 && !mute_in) begin
        io_rsp_out <= '{ack: 1'b1, status: stat_in, data: data_in};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mcnt_q        <= 2'h0;
      mod_ready_out <= 1'b0;
    end else begin
      mcnt_q        <= (mod_req_in.valid && !mod_ready_out) ? mcnt_q + 2'h1 : 2'h0;
      mod_ready_out <= mod_req_in.valid && !mod_ready_out && mcnt_q == 2'h2;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/cie_io_exec_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cie_io_exec_tb_top;
  import cie_pkg::*;
  logic         clk_in = 1'b0;
  logic         rst_b_in = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mute = 1'b0, pready, pslverr, mrdy, last_err;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h00000000, prdata;
  logic [15:0]  stat = 16'h0000, dat = 16'h0000;
  cie_io_req_s  io_req, last_io;
  cie_io_rsp_s  io_rsp;
  cie_mod_req_s mod_req, last_mod;
  cie_dtab_wr_s dtab_wr, last_dtab;
  int           bad_count = 0, num_checks = 0;

  always #4 clk_in = ~clk_in;

  cie_io_exec #(.NORESP_CYCLES(8)) i_cie_io_exec (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .io_req_out(io_req), .io_rsp_in(io_rsp),
    .mod_req_out(mod_req), .mod_ready_in(mrdy), .dtab_wr_out(dtab_wr));
  cie_dev_model i_cie_dev_model (.clk_in(clk_in), .rst_b_in(rst_b_in), .io_req_in(io_req),
    .mod_req_in(mod_req), .mute_in(mute), .stat_in(stat), .data_in(dat), .io_rsp_out(io_rsp),
    .mod_ready_out(mrdy));

  always @(posedge clk_in) begin
    if (io_req.valid && io_rsp.ack) last_io <= io_req;
    if (mod_req.valid && mrdy) last_mod <= mod_req;
    if (dtab_wr.valid) last_dtab <= dtab_wr;
    if (psel && penable && pready) last_err <= pslverr;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One idle cycle closes each transfer, so back-to-back calls never drive psel twice in one step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    apb(1'b1, a, {16'h0000, d}, r);
  endtask

  task automatic exec(input logic [15:0] ins, input logic [1:0] cc, input logic [4:0] dep,
                      input logic [15:0] top, output logic [31:0] st);
    logic [31:0] r;
    wr(REG_INSTR, ins);
    st = 32'h00000001;
    while (st[ST_BUSY] !== 1'b0) apb(1'b0, REG_STATUS, 32'h00000000, st);
    chk(32'(st[ST_CC_LSB +: 2]), 32'(cc));
    chk(32'(st[ST_DEPTH_LSB +: 5]), 32'(dep));
    apb(1'b0, REG_STACK, 32'h00000000, r);
    chk(r, {16'h0000, top});
  endtask

  task automatic rst();
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
  endtask

  task automatic t_ctrl();
    logic [31:0] s;
    rst();
    wr(REG_POP, 16'h0000);
    chk(32'(last_err), 32'h00000001);
    wr(REG_STACK, 16'h0005);
    wr(REG_STACK, 16'h1234);
    exec(16'h30B1, CC_EQUAL, 5'h01, 16'h0005, s);
    chk(32'(last_io.kind), 32'(KIND_CONTROL));
    chk({last_io.devnum, last_io.data}, 32'h00051234);
    $display("control test done");
  endtask

  task automatic t_nores();
    logic [31:0] s;
    rst();
    wr(REG_STACK, 16'h0005);
    wr(REG_STACK, 16'h1234);
    mute <= 1'b1;
    exec(16'h30B1, CC_LESS, 5'h02, 16'h1234, s);
    mute <= 1'b0;
    $display("no response test done");
  endtask

  task automatic t_read();
    logic [31:0] s;
    rst();
    wr(REG_STACK, 16'h0007);
    stat <= 16'h4000;
    dat <= 16'hBEEF;
    exec(16'h3080, CC_EQUAL, 5'h02, 16'hBEEF, s);
    chk({13'h0000, last_io.kind, last_io.devnum}, {13'h0000, KIND_READ, 16'h0007});
    stat <= 16'h0123;
    exec(16'h3081, CC_GREATER, 5'h03, 16'h0123, s);
    $display("read test done");
  endtask

  task automatic t_write();
    logic [31:0] s;
    rst();
    wr(REG_STACK, 16'h0003);
    wr(REG_STACK, 16'h5A5A);
    stat <= 16'h4000;
    exec(16'h3091, CC_EQUAL, 5'h01, 16'h0003, s);
    chk({13'h0000, last_io.kind, last_io.data}, {13'h0000, KIND_WRITE, 16'h5A5A});
    stat <= 16'h0321;
    exec(16'h30A0, CC_EQUAL, 5'h02, 16'h0321, s);
    $display("write and test test done");
  endtask

  task automatic t_start();
    logic [31:0] s;
    rst();
    wr(REG_TABLE, 16'h0100);
    wr(REG_STACK, 16'h0002);
    wr(REG_STACK, 16'h0777);
    stat <= 16'h8000;
    exec(16'h3071, CC_EQUAL, 5'h01, 16'h0002, s);
    chk({last_dtab.addr, last_dtab.data}, 32'h01080777);
    chk(32'(last_io.kind), 32'(KIND_START));
    wr(REG_STACK, 16'h0777);
    stat <= 16'h4000;
    exec(16'h3071, CC_GREATER, 5'h03, 16'h4000, s);
    $display("start test done");
  endtask

  task automatic t_mod();
    logic [31:0] s;
    rst();
    wr(REG_STACK, 16'h0025);
    wr(REG_STACK, 16'hC0DE);
    exec(16'h30C1, CC_GREATER, 5'h02, 16'hC0DE, s);
    chk(32'(s[ST_MODE_TRAP]), 32'h00000001);
    wr(REG_MODE, 16'h0001);
    exec(16'h30C1, CC_GREATER, 5'h01, 16'h0025, s);
    chk(32'({last_mod.modnum, last_mod.cmd, last_mod.data}), 32'h0016C0DE);
    exec(16'h30C5, CC_GREATER, 5'h01, 16'h0025, s);
    chk(32'(s[ST_UNDER]), 32'h00000001);
    $display("module command test done");
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    t_ctrl();
    t_nores();
    t_read();
    t_write();
    t_start();
    t_mod();
    report_and_stop();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
